//--- verilog/dpm_pkg.sv
package dpm_pkg;

   // Channel and image sizes
   localparam int unsigned DPM_CHANNELS   = 16;
   localparam int unsigned DPM_GROUP_SIZE = 4;
   localparam int unsigned DPM_GROUPS     = DPM_CHANNELS / DPM_GROUP_SIZE;

   // Module slots and status module image size in bytes
   localparam logic [7:0] DPM_STATUS_SLOT  = 8'h01;
   localparam logic [7:0] DPM_IO_SLOT      = 8'h02;
   localparam logic [7:0] DPM_STATUS_BYTES = 8'h04;

   // Status word bit positions
   localparam int unsigned DPM_ST_SUP_UNDER = 5;
   localparam int unsigned DPM_ST_SUP_OVER  = 4;
   localparam int unsigned DPM_ST_OUT_FAULT = 0;

   // Failsafe behaviour codes
   localparam logic [1:0] DPM_FS_CLEAR = 2'h0;
   localparam logic [1:0] DPM_FS_SET   = 2'h1;
   localparam logic [1:0] DPM_FS_HOLD  = 2'h2;
   localparam logic [1:0] DPM_FS_PAT   = 2'h3;

   // Values after reset
   localparam logic [1:0]  DPM_FS_CODE_RST = DPM_FS_CLEAR;
   localparam logic [15:0] DPM_FS_PAT_RST  = 16'h0000;
   localparam logic        DPM_SWAP_RST    = 1'b0;

   // Output state: failsafe or live cyclic data
   typedef enum logic [1:0] {
      DPM_ST_FAILSAFE = 2'b01,
      DPM_ST_RUN      = 2'b10
   } dpm_mode_type;

   // Startup parameters of the channel module
   typedef struct packed {
      logic        swap;
      logic [1:0]  fs_code;
      logic [15:0] fs_pat;
   } dpm_param_type;

   // Whole state of the mapper
   typedef struct packed {
      dpm_mode_type  mode;
      dpm_param_type par;
      logic [15:0]   out;
      logic [15:0]   dir;
      logic [15:0]   in_img;
      logic [31:0]   status;
      logic [3:0]    grp;
      logic          stn_fault;
   } dpm_state_type;

endpackage

//--- verilog/dpm_byte_swap.sv
// Swaps the two bytes of a process data image when enabled
module dpm_byte_swap
   import dpm_pkg::*;
#(
   parameter int unsigned WIDTH = 16
)
(
   // Control
   input  wire logic             i_swap,
   // Data
   input  wire logic [WIDTH-1:0] i_data,
   output logic      [WIDTH-1:0] o_data
);

   localparam int unsigned HALF = WIDTH / 2;

   // Exchange upper and lower halves
   always_comb
   begin
      if (i_swap)
         o_data = {i_data[HALF-1:0], i_data[WIDTH-1:HALF]};
      else
         o_data = i_data;
   end

endmodule

//--- verilog/dpm_led_drive.sv
// Per-channel yellow and red indicator drive
module dpm_led_drive
   import dpm_pkg::*;
#(
   parameter int unsigned CHANNELS = DPM_CHANNELS
)
(
   // Channel state
   input  wire logic [CHANNELS-1:0] i_dir_out,
   input  wire logic [CHANNELS-1:0] i_out_lvl,
   input  wire logic [CHANNELS-1:0] i_in_lvl,
   input  wire logic [CHANNELS-1:0] i_fault,
   // Indicators, index is 8*byte+bit
   output logic      [CHANNELS-1:0] o_yellow,
   output logic      [CHANNELS-1:0] o_red
);

   // Indicator select per channel
   // index is byte, bit
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         o_red[i] = i_dir_out[i] & i_fault[i];
         if (i_dir_out[i])
            o_yellow[i] = i_out_lvl[i] & ~o_red[i];
         else
            o_yellow[i] = i_in_lvl[i];
      end
   end

endmodule

//--- verilog/dpm_mapper.sv
// Functional notes
// - Input channel lights yellow while its input is set, dark otherwise.
// - Output channel lights yellow while driven high and not red, dark otherwise.
// - Output channel shows red while short-circuited or overloaded.
// - Indicator label is byte digit then bit digit.
// - Status module in slot 1 with 4 bytes; channels in slot 2.
// - Status word: bit 5 undervoltage, bit 4 overvoltage, bit 0 outputs.
// - Status word refreshed at every cyclic exchange.
// - Direction follows which process data bit the controller uses.
// - Output channel state is mirrored into the input image.
// - Unswapped: byte 0 is channels 1-8, byte 1 is 9-16.
// - Swap option exchanges bytes 0 and 1 of both images.
// - Failsafe code: 0 clear, 1 set, 2 hold, 3 pattern.
// - Substitute pattern, default zero, used only with code 3.
// - Pattern bits map to fixed outputs regardless of swap.
// - Failsafe and swap parameters arrive as startup parameters.
// - Swap parameter is one bit, zero by default.
// - Station fault indicator on while any diagnostic was present at the last cyclic exchange.
// - Channel overload reported per group of four channels.
module dpm_mapper
   import dpm_pkg::*;
(
   // Clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_nrst,
   // Cyclic exchange with the controller
   input  wire logic          i_cyc_strobe,
   input  wire logic          i_cyc_valid,
   input  wire logic [15:0]   i_out_bytes,
   input  wire logic [15:0]   i_out_used,
   output logic      [15:0]   o_in_bytes,
   output logic      [31:0]   o_status_word,
   // Module layout
   output logic      [7:0]    o_status_slot,
   output logic      [7:0]    o_status_bytes,
   output logic      [7:0]    o_io_slot,
   // Startup parameters
   input  wire logic          i_param_load,
   input  wire dpm_param_type i_param,
   // Channel pins and supervision
   input  wire logic [15:0]   i_chan_in,
   output logic      [15:0]   o_chan_out,
   output logic      [15:0]   o_chan_oe,
   input  wire logic [15:0]   i_chan_fault,
   input  wire logic          i_sup_under,
   input  wire logic          i_sup_over,
   // Indicators and diagnostics
   output logic      [15:0]   o_led_yellow,
   output logic      [15:0]   o_led_red,
   output logic               o_station_fault_indicator,
   output logic      [3:0]    o_group_fault
);

   dpm_state_type st_q;
   dpm_state_type st_d;
   logic [15:0]   out_phys;
   logic [15:0]   used_phys;
   logic [15:0]   in_proc;
   logic [15:0]   in_phys;
   logic [15:0]   fault_live;
   logic          take_live;

   // Process image to channel order for output data
   // byte to channel map
   dpm_byte_swap #(.WIDTH(16)) u_swap_out
   (
      .i_swap (st_q.par.swap),
      .i_data (i_out_bytes),
      .o_data (out_phys)
   );

   // Same mapping for the direction mask
   // direction from data use
   dpm_byte_swap #(.WIDTH(16)) u_swap_dir
   (
      .i_swap (st_q.par.swap),
      .i_data (i_out_used),
      .o_data (used_phys)
   );

   // Channel order back to process image for input data
   // swap both images
   dpm_byte_swap #(.WIDTH(16)) u_swap_in
   (
      .i_swap (st_q.par.swap),
      .i_data (in_phys),
      .o_data (in_proc)
   );

   // Output channels read back the pin, inputs read the sensor
   // output mirrored to input
   assign in_phys    = i_chan_in;
   assign fault_live = i_chan_fault & st_q.dir;
   assign take_live  = i_cyc_strobe & i_cyc_valid;

   // Next state
   always_comb
   begin
      st_d = st_q;
      if (i_param_load)
         st_d.par = i_param;
      if (i_cyc_strobe)
      begin
         st_d.in_img = in_proc;
         st_d.status = 32'h0000_0000;
         st_d.status[DPM_ST_SUP_UNDER] = i_sup_under;
         st_d.status[DPM_ST_SUP_OVER]  = i_sup_over;
         st_d.status[DPM_ST_OUT_FAULT] = |fault_live;
         for (int g = 0; g < DPM_GROUPS; g++)
            st_d.grp[g] = |fault_live[g*DPM_GROUP_SIZE +: DPM_GROUP_SIZE];
         st_d.stn_fault = i_sup_under | i_sup_over | (|fault_live);
      end
      if (i_cyc_strobe)
         st_d.mode = i_cyc_valid ? DPM_ST_RUN : DPM_ST_FAILSAFE;
      unique case (st_q.mode)
         DPM_ST_RUN:
         begin
            if (take_live)
            begin
               st_d.out = out_phys;
               st_d.dir = used_phys;
            end
         end
         DPM_ST_FAILSAFE:
         begin
            if (take_live)
            begin
               st_d.out = out_phys;
               st_d.dir = used_phys;
            end
            else
            begin
               unique case (st_q.par.fs_code)
                  DPM_FS_CLEAR: st_d.out = 16'h0000;
                  DPM_FS_SET:   st_d.out = 16'hffff;
                  DPM_FS_HOLD:  st_d.out = st_q.out;
                  DPM_FS_PAT:   st_d.out = st_q.par.fs_pat;
               endcase
            end
         end
         default:
         begin
            st_d.mode = DPM_ST_FAILSAFE;
            st_d.out  = 16'h0000;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_q.mode       <= DPM_ST_FAILSAFE;
         st_q.par.swap    <= DPM_SWAP_RST;
         st_q.par.fs_code <= DPM_FS_CODE_RST;
         st_q.par.fs_pat  <= DPM_FS_PAT_RST;
         st_q.out        <= 16'h0000;
         st_q.dir        <= 16'h0000;
         st_q.in_img     <= 16'h0000;
         st_q.status     <= 32'h0000_0000;
         st_q.grp        <= 4'h0;
         st_q.stn_fault  <= 1'b0;
      end
      else
         st_q <= st_d;
   end

   // Channel indicators
   // yellow on driven high
   dpm_led_drive #(.CHANNELS(16)) u_led
   (
      .i_dir_out (st_q.dir),
      .i_out_lvl (st_q.out),
      .i_in_lvl  (i_chan_in),
      .i_fault   (i_chan_fault),
      .o_yellow  (o_led_yellow),
      .o_red     (o_led_red)
   );

   // Outputs
   // only output channels drive
   assign o_chan_out     = st_q.out & st_q.dir;
   assign o_chan_oe      = st_q.dir;
   assign o_in_bytes     = st_q.in_img;
   assign o_status_word  = st_q.status;
   assign o_group_fault  = st_q.grp;
   assign o_station_fault_indicator = st_q.stn_fault;
   assign o_status_slot  = DPM_STATUS_SLOT;
   assign o_status_bytes = DPM_STATUS_BYTES;
   assign o_io_slot      = DPM_IO_SLOT;

   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   status_layout_a: assert property (
      i_cyc_strobe |=> o_status_word == {26'h0, $past(i_sup_under),
         $past(i_sup_over), 3'h0, $past(|(i_chan_fault & st_q.dir))})
      else $error("status word layout wrong");

   status_refresh_a: assert property (
      !i_cyc_strobe |=> $stable(o_status_word))
      else $error("status changed without exchange");

   plain_map_a: assert property (
      take_live && !st_q.par.swap && !i_param_load
      |=> o_chan_out == ($past(i_out_bytes) & $past(i_out_used)))
      else $error("unswapped output map wrong");

   swap_map_a: assert property (
      take_live && st_q.par.swap && !i_param_load
      |=> st_q.out == {$past(i_out_bytes[7:0]), $past(i_out_bytes[15:8])})
      else $error("swapped output map wrong");

   readback_a: assert property (
      i_cyc_strobe && !st_q.par.swap && !i_param_load
      |=> o_in_bytes == $past(i_chan_in))
      else $error("input image not pin level");

   fs_clear_a: assert property (
      st_q.mode == DPM_ST_FAILSAFE && !take_live
      && st_q.par.fs_code == DPM_FS_CLEAR |=> st_q.out == 16'h0000)
      else $error("failsafe clear not applied");

   fs_set_a: assert property (
      st_q.mode == DPM_ST_FAILSAFE && !take_live
      && st_q.par.fs_code == DPM_FS_SET |=> st_q.out == 16'hffff)
      else $error("failsafe set not applied");

   fs_hold_a: assert property (
      st_q.mode == DPM_ST_FAILSAFE && !take_live
      && st_q.par.fs_code == DPM_FS_HOLD |=> $stable(st_q.out))
      else $error("failsafe hold lost value");

   fs_pattern_a: assert property (
      st_q.mode == DPM_ST_FAILSAFE && !take_live
      && st_q.par.fs_code == DPM_FS_PAT
      |=> st_q.out == $past(st_q.par.fs_pat))
      else $error("substitute pattern not applied");

   fs_entry_a: assert property (
      i_cyc_strobe && !i_cyc_valid |=> st_q.mode == DPM_ST_FAILSAFE)
      else $error("no failsafe on missing data");

   stn_fault_a: assert property (
      o_station_fault_indicator == (|o_status_word))
      else $error("station fault mismatch");

   group_sum_a: assert property (
      o_status_word[DPM_ST_OUT_FAULT] == (|o_group_fault))
      else $error("group faults disagree with status");

   red_prio_a: assert property (
      (o_led_red & o_led_yellow) == 16'h0000)
      else $error("red and yellow both on");

   in_led_a: assert property (
      ((o_led_yellow ^ i_chan_in) & ~st_q.dir) == 16'h0000)
      else $error("input indicator wrong");

   out_led_a: assert property (
      ((o_led_yellow ^ (o_chan_out & ~o_led_red)) & o_chan_oe) == 16'h0000)
      else $error("output indicator wrong");

   red_fault_a: assert property (
      ((i_chan_fault & o_chan_oe) & ~o_led_red) == 16'h0000)
      else $error("faulted output not red");

   dir_follow_a: assert property (
      take_live && !st_q.par.swap |=> o_chan_oe == $past(i_out_used))
      else $error("direction not taken from used bits");

   swap_readback_a: assert property (
      i_cyc_strobe && st_q.par.swap
      |=> o_in_bytes == {$past(i_chan_in[7:0]), $past(i_chan_in[15:8])})
      else $error("swapped input image wrong");

   // Main scenarios
   cov_run: cover property (take_live ##1 st_q.mode == DPM_ST_RUN);
   cov_fs_pat: cover property (st_q.mode == DPM_ST_FAILSAFE
      && st_q.par.fs_code == DPM_FS_PAT ##1 st_q.out != 16'h0000);
   cov_swap: cover property (take_live && st_q.par.swap);
   cov_red: cover property (o_led_red != 16'h0000);

endmodule

//--- testbench/dpm_ctrl_model.sv
// Network controller side: cyclic exchange and startup parameters
module dpm_ctrl_model
   import dpm_pkg::*;
(
   // Clock
   input  wire logic     i_ref_clk,
   // Cyclic exchange towards the mapper
   output logic          o_cyc_strobe,
   output logic          o_cyc_valid,
   output logic [15:0]   o_out_bytes,
   output logic [15:0]   o_out_used,
   // Startup parameters
   output logic          o_param_load,
   output dpm_param_type o_param
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels from time zero
   initial
   begin
      o_cyc_strobe = 1'h0;
      o_cyc_valid  = 1'h0;
      o_out_bytes  = 16'h0000;
      o_out_used   = 16'h0000;
      o_param_load = 1'h0;
      o_param      = '0;
   end

   task automatic load(input logic sw, input logic [1:0] code,
                       input logic [15:0] pat);
      @(posedge i_ref_clk);
      o_param_load <= 1'h1;
      o_param      <= '{swap: sw, fs_code: code, fs_pat: pat};
      @(posedge i_ref_clk);
      o_param_load <= 1'h0;
      o_param      <= dpm_param_type'(~{sw, code, pat}); // Stale lines
   endtask

   // outputs only on bits in use
   task automatic exchange(input logic vld, input logic [15:0] data,
                           input logic [15:0] used);
      @(posedge i_ref_clk);
      o_cyc_strobe <= 1'h1;
      o_cyc_valid  <= vld;
      o_out_bytes  <= data & used;
      o_out_used   <= used;
      @(posedge i_ref_clk);
      o_cyc_strobe <= 1'h0;
      o_cyc_valid  <= ~vld;
      o_out_bytes  <= ~(data & used); // Not held after the strobe
   endtask
endmodule

//--- testbench/tb.sv
module tb
   import dpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        sw;
      logic        vld;
      logic [1:0]  code;
      logic [15:0] pat, data, used, ext, flt, eo, eoe;
      logic        und, ovr;
   } dpm_row_type;

   // Rows: sw vld code pat data used ext flt out oe und ovr
   localparam dpm_row_type ROWS [8] = '{
      '{1'h0, 1'h1, 2'h0, 16'h0000, 16'h00a5, 16'h00ff, 16'h3c00,
        16'h0000, 16'h00a5, 16'h00ff, 1'h0, 1'h0},
      '{1'h1, 1'h1, 2'h0, 16'h0000, 16'h12f0, 16'hff00, 16'h5a00,
        16'h0010, 16'h0012, 16'h00ff, 1'h1, 1'h0},
      '{1'h0, 1'h1, 2'h0, 16'h0000, 16'h5500, 16'hff00, 16'h000f,
        16'h8000, 16'h5500, 16'hff00, 1'h0, 1'h1},
      '{1'h0, 1'h0, 2'h2, 16'h0000, 16'h0000, 16'h0000, 16'h000f,
        16'h0000, 16'h5500, 16'hff00, 1'h0, 1'h0},
      '{1'h0, 1'h0, 2'h1, 16'h0000, 16'h0000, 16'h0000, 16'h000f,
        16'h0000, 16'hff00, 16'hff00, 1'h0, 1'h0},
      '{1'h0, 1'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000, 16'h000f,
        16'h0000, 16'h0000, 16'hff00, 1'h0, 1'h0},
      '{1'h1, 1'h0, 2'h3, 16'h9a3c, 16'h0000, 16'h0000, 16'h000f,
        16'h0000, 16'h9a00, 16'hff00, 1'h0, 1'h0},
      '{1'h0, 1'h1, 2'h3, 16'h9a3c, 16'h0f0f, 16'hffff, 16'h0000,
        16'h0000, 16'h0f0f, 16'hffff, 1'h0, 1'h0}
   };

   logic          i_ref_clk, i_nrst, cyc_strobe, cyc_valid, param_load;
   logic          i_sup_under, i_sup_over;
   logic [15:0]   out_bytes, out_used, ext_in, i_chan_fault, chan_in;
   logic [15:0]   in_bytes, chan_out, chan_oe, led_y, led_r, pin, red;
   logic [31:0]   status_word;
   logic [7:0]    st_slot, st_bytes, io_slot;
   logic [3:0]    grp_fault, grp;
   logic          stn_fault;
   dpm_param_type param;
   dpm_row_type   row;
   int            miscompares, n_checks, cycles;

   // Clock
   always #5 i_ref_clk = ~i_ref_clk;

   // Pin level from the driver and the external load
   assign chan_in = (chan_oe & chan_out) | (~chan_oe & ext_in);

   dpm_ctrl_model u_dpm_ctrl_model (
      .i_ref_clk(i_ref_clk), .o_cyc_strobe(cyc_strobe),
      .o_cyc_valid(cyc_valid), .o_out_bytes(out_bytes),
      .o_out_used(out_used), .o_param_load(param_load), .o_param(param));

   dpm_mapper u_dpm_mapper (
      .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cyc_strobe(cyc_strobe),
      .i_cyc_valid(cyc_valid), .i_out_bytes(out_bytes),
      .i_out_used(out_used), .o_in_bytes(in_bytes),
      .o_status_word(status_word), .o_status_slot(st_slot),
      .o_status_bytes(st_bytes), .o_io_slot(io_slot),
      .i_param_load(param_load), .i_param(param), .i_chan_in(chan_in),
      .o_chan_out(chan_out), .o_chan_oe(chan_oe),
      .i_chan_fault(i_chan_fault), .i_sup_under(i_sup_under),
      .i_sup_over(i_sup_over), .o_led_yellow(led_y), .o_led_red(led_r),
      .o_station_fault_indicator(stn_fault), .o_group_fault(grp_fault));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Cycle ceiling against hangs
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         miscompares++;
         complete_run();
      end
   end

   initial
   begin
      i_ref_clk = 1'h0;
      i_nrst = 1'h0;
      i_sup_under = 1'h0;
      i_sup_over = 1'h0;
      ext_in = 16'h0000;
      i_chan_fault = 16'h0000;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk(st_slot, 8'h01);
      chk(st_bytes, 8'h04);
      chk(io_slot, 8'h02);
      chk(chan_oe, 16'h0000);
      repeat (3) @(posedge i_ref_clk);
      i_nrst <= 1'h1;
      @(posedge i_ref_clk);
      #1;
      chk(chan_out, 16'h0000);
      $display("reset test done");
      // Table rows, each exchange sent twice so pins settle
      for (int r = 0; r < 8; r++)
      begin
         row = ROWS[r];
         u_dpm_ctrl_model.load(row.sw, row.code, row.pat);
         ext_in <= row.ext;
         i_chan_fault <= row.flt;
         i_sup_under <= row.und;
         i_sup_over <= row.ovr;
         repeat (2) u_dpm_ctrl_model.exchange(row.vld, row.data, row.used);
         @(posedge i_ref_clk);
         #1;
         pin = (row.eoe & row.eo) | (~row.eoe & row.ext);
         red = row.eoe & row.flt;
         for (int g = 0; g < 4; g++)
            grp[g] = |red[4*g +: 4];
         chk(chan_out, row.eo);
         chk(chan_oe, row.eoe);
         chk(in_bytes, row.sw ? {pin[7:0], pin[15:8]} : pin);
         chk(status_word, {26'h0, row.und, row.ovr, 3'h0, |red});
         chk(led_r, red);
         chk(led_y, pin & ~red);
         chk(grp_fault, grp);
         chk(stn_fault, row.und | row.ovr | (|red));
         $display("row %0d done", r);
      end
      // Diagnostics change between exchanges
      @(posedge i_ref_clk);
      i_sup_under <= 1'h1;
      i_chan_fault <= 16'h0001;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk(status_word, 32'h00000000);
      chk(led_r, 16'h0001);
      chk(led_y, 16'h0f0e);
      u_dpm_ctrl_model.exchange(1'h1, 16'h0f0f, 16'hffff);
      @(posedge i_ref_clk);
      #1;
      chk(status_word, 32'h00000021);
      chk(stn_fault, 1'h1);
      $display("refresh test done");
      // Second reset restores defaults; swap and set loaded first
      u_dpm_ctrl_model.load(1'h1, DPM_FS_SET, 16'h0000);
      @(posedge i_ref_clk);
      i_nrst <= 1'h0;
      i_sup_under <= 1'h0;
      i_chan_fault <= 16'h0000;
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk(chan_oe, 16'h0000);
      chk(status_word, 32'h00000000);
      @(posedge i_ref_clk);
      i_nrst <= 1'h1;
      u_dpm_ctrl_model.exchange(1'h1, 16'h0100, 16'hff00);
      @(posedge i_ref_clk);
      #1;
      chk(chan_out, 16'h0100);
      u_dpm_ctrl_model.exchange(1'h0, 16'h0000, 16'h0000);
      @(posedge i_ref_clk);
      #1;
      chk(chan_out, 16'h0000);
      $display("second reset test done");
      complete_run();
   end
endmodule
